// ### design/alarm_out_defs.vh
// Constants for the alarm and analog output configuration block.
// Assumes inclusion by bare name from design files.
`ifndef ALARM_OUT_DEFS_VH
`define ALARM_OUT_DEFS_VH
`define ADDR_ORDERED_POWER 16'h0FAA
`define ADDR_ALARM_QTY 16'h0FAF
`define ADDR_ALARM_MODE 16'h0FB0
`define ADDR_ALARM_OFF_THR 16'h0FB1
`define ADDR_ALARM_ON_THR 16'h0FB2
`define ADDR_ALARM_ON_DLY 16'h0FB3
`define ADDR_ALARM_OFF_DLY 16'h0FB4
`define ADDR_ALARM_RELOCK 16'h0FB5
`define ADDR_OUT_QTY 16'h0FD0
`define ADDR_OUT_IN_LOW 16'h0FD1
`define ADDR_OUT_IN_HIGH 16'h0FD2
`define ADDR_OUT_CUR_LOW 16'h0FD3
`define ADDR_OUT_CUR_HIGH 16'h0FD4
`define ADDR_OUT_MODE 16'h0FD5
`define ADDR_OUT_ERR_VAL 16'h0FD6
`define QTY_PHASE_ONE_VOLTAGE 16'h0001
`define QTY_MEAN_CURRENT 16'h0017
`define QTY_USED_ORDERED_POWER 16'h0023
`define MODE_NORMAL 16'h0000
`define FULL_SCALE_TENTHS 32'h000003E8
`define CLK_HZ 32'h00989680
`define RESET_WORD 16'h0000
`define ERR_VALUE_RESET 16'h0960
`endif

// ### design/second_tick.v
// One-second tick generator.
// Assumes i_sys_clk at the rate given by the CLK_HZ parameter.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_out_defs.vh"
module second_tick #(
   parameter CLK_HZ = `CLK_HZ
) (
   input wire i_sys_clk,
   input wire i_rst,
   output reg o_tick
);
   reg [31:0] count_reg;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         count_reg <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (count_reg >= CLK_HZ - 1) begin
         count_reg <= 32'h00000000;
         o_tick <= 1'b1; // R18
      end else begin
         count_reg <= count_reg + 32'h00000001;
         o_tick <= 1'b0;
      end
   end
endmodule // second_tick
`default_nettype wire

// ### design/linear_scaler.v
// Linear map of a source percentage onto an output current setpoint.
// Assumes limits stay steady while a result is in use; result is one cycle late.
`timescale 1ns/1ps
`default_nettype none
module linear_scaler (
   input wire i_sys_clk,
   input wire i_rst,
   input wire signed [15:0] i_src,
   input wire signed [15:0] i_in_low,
   input wire signed [15:0] i_in_high,
   input wire signed [15:0] i_cur_low,
   input wire signed [15:0] i_cur_high,
   output reg signed [15:0] o_cur
);
   reg signed [47:0] num;
   reg signed [47:0] span;
   reg signed [47:0] res;
   always @* begin
      num = ($signed({{32{i_src[15]}}, i_src}) - $signed({{32{i_in_low[15]}}, i_in_low}))
         * ($signed({{32{i_cur_high[15]}}, i_cur_high})
         - $signed({{32{i_cur_low[15]}}, i_cur_low}));
      span = $signed({{32{i_in_high[15]}}, i_in_high}) - $signed({{32{i_in_low[15]}}, i_in_low});
      if (span == 48'sh0)
         res = $signed({{32{i_cur_low[15]}}, i_cur_low});
      else
         res = num / span + $signed({{32{i_cur_low[15]}}, i_cur_low}); // R17
   end
   always @(posedge i_sys_clk) begin
      if (i_rst)
         o_cur <= 16'sh0000;
      else
         o_cur <= res[15:0];
   end
endmodule // linear_scaler
`default_nettype wire

// ### design/alarm_analog_config.v
// Threshold alarm with delays and relock, plus output-1 current scaler.
// Assumes measured inputs arrive as signed tenths of percent of rating, with
// separate error flags standing in for the +-1e20 markers; inputs synchronous.
// Functional notes
// R01 - Selector value 1 monitors the phase one voltage.
// R02 - Selector value 35 monitors percent of ordered power used.
// R03 - Thresholds and input limits are signed tenths of percent of rating.
// R04 - Normal mode: on at on-threshold, off at off-threshold.
// R05 - Software sets off-threshold below on-threshold for hysteresis.
// R06 - Switch on after condition persists on-delay seconds; zero immediate.
// R07 - Switch off after condition persists off-delay seconds; zero immediate.
// R08 - After switch-off, block re-switching for relock seconds; zero none.
// R09 - Ordered power register is 100 percent reference for used power.
// R10 - Used power comes from 15-minute clock-synchronized averaged active power.
// R11 - Output selector value 23 selects three-phase mean current.
// R12 - Output input limits are signed tenths of percent; negative allowed.
// R13 - Output current limits are signed hundredths of a milliampere.
// R14 - Output mode zero selects normal scaling.
// R15 - Source error or overflow drives the error-value current.
// R16 - Underflow reads as minus marker, overflow or error as plus marker.
// R17 - Normal mode interpolates current linearly between the limits.
// R18 - Timers count whole seconds from a tick and restart on lapse.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_out_defs.vh"
module alarm_analog_config #(
   parameter CLK_HZ = `CLK_HZ
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [15:0] i_reg_addr,
   input wire [15:0] i_reg_wdata,
   input wire signed [15:0] i_phase_one_voltage,
   input wire i_phase_one_voltage_err,
   input wire signed [15:0] i_mean_current,
   input wire i_mean_current_err,
   input wire signed [15:0] i_avg_active_power,
   input wire i_avg_active_power_err,
   output reg [15:0] o_reg_rdata,
   output reg o_reg_ack,
   output reg o_reg_err,
   output reg o_alarm,
   output reg signed [15:0] o_current_setpoint,
   output reg o_current_fault
);
   localparam ST_OFF = 2'b00;
   localparam ST_ON = 2'b01;
   localparam ST_LOCK = 2'b10;

   reg [15:0] ordered_power_reg;
   reg [15:0] alarm_qty_reg;
   reg [15:0] alarm_mode_reg;
   reg signed [15:0] off_thr_reg;
   reg signed [15:0] on_thr_reg;
   reg [15:0] on_dly_reg;
   reg [15:0] off_dly_reg;
   reg [15:0] relock_reg;
   reg [15:0] out_qty_reg;
   reg signed [15:0] in_low_reg;
   reg signed [15:0] in_high_reg;
   reg signed [15:0] cur_low_reg;
   reg signed [15:0] cur_high_reg;
   reg [15:0] out_mode_reg;
   reg signed [15:0] err_val_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [15:0] sec_reg;
   reg [15:0] sec_next;
   reg signed [15:0] used_power_reg;
   reg used_power_err_reg;
   reg signed [15:0] alarm_src;
   reg alarm_src_err;
   reg signed [15:0] out_src;
   reg out_src_err;
   reg [15:0] rd_data;
   reg rd_hit;
   wire tick;
   wire signed [15:0] scaled;

   function signed [15:0] sat16;
      input signed [31:0] v;
      begin
         if (v > 32'sh00007FFF)
            sat16 = 16'sh7FFF;
         else if (v < -32'sh00008000)
            sat16 = 16'sh8000;
         else
            sat16 = v[15:0];
      end
   endfunction

   // Count must pass the limit: the first tick lands anywhere in the first second
   function timer_done;
      input [15:0] count;
      input [15:0] limit;
      begin
         timer_done = (limit == `RESET_WORD) || (count > limit);
      end
   endfunction

   second_tick #(
      .CLK_HZ(CLK_HZ)
   ) tick_gen (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .o_tick(tick)
   );

   linear_scaler scaler (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_src(out_src),
      .i_in_low(in_low_reg),
      .i_in_high(in_high_reg),
      .i_cur_low(cur_low_reg),
      .i_cur_high(cur_high_reg),
      .o_cur(scaled)
   );

   // Divide once per cycle into a register; keeps the path out of the alarm
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         used_power_reg <= 16'sh0000;
         used_power_err_reg <= 1'b0;
      end else if (ordered_power_reg == `RESET_WORD) begin
         used_power_reg <= 16'sh7FFF;
         used_power_err_reg <= 1'b1;
      end else begin
         used_power_reg <= sat16(($signed({{16{i_avg_active_power[15]}}, i_avg_active_power})
            * $signed(`FULL_SCALE_TENTHS)) / $signed({16'h0000, ordered_power_reg})); // R09 R10
         used_power_err_reg <= i_avg_active_power_err; // R16
      end
   end

   always @* begin
      alarm_src = 16'sh0000;
      alarm_src_err = 1'b1;
      case (alarm_qty_reg)
         `QTY_PHASE_ONE_VOLTAGE: begin
            alarm_src = i_phase_one_voltage; // R01 R03
            alarm_src_err = i_phase_one_voltage_err;
         end
         `QTY_USED_ORDERED_POWER: begin
            alarm_src = used_power_reg; // R02
            alarm_src_err = used_power_err_reg;
         end
         `QTY_MEAN_CURRENT: begin
            alarm_src = i_mean_current;
            alarm_src_err = i_mean_current_err;
         end
         default: begin
            alarm_src = 16'sh0000;
            alarm_src_err = 1'b1;
         end
      endcase
      out_src = 16'sh0000;
      out_src_err = 1'b1;
      case (out_qty_reg)
         `QTY_MEAN_CURRENT: begin
            out_src = i_mean_current; // R11 R12
            out_src_err = i_mean_current_err;
         end
         `QTY_PHASE_ONE_VOLTAGE: begin
            out_src = i_phase_one_voltage;
            out_src_err = i_phase_one_voltage_err;
         end
         `QTY_USED_ORDERED_POWER: begin
            out_src = used_power_reg;
            out_src_err = used_power_err_reg;
         end
         default: begin
            out_src = 16'sh0000;
            out_src_err = 1'b1;
         end
      endcase
   end

   // Only mode 0 is modelled; other modes release the alarm after the off-delay and keep it off.
   // Error source counts as neither on nor off condition: OFF and ON hold; the relock timer still runs.
   always @* begin
      state_next = state_reg;
      sec_next = sec_reg;
      case (state_reg)
         ST_OFF: begin
            if (alarm_mode_reg == `MODE_NORMAL && !alarm_src_err && alarm_src >= on_thr_reg) begin
               if (timer_done(sec_reg, on_dly_reg)) begin // R04 R06
                  state_next = ST_ON;
                  sec_next = `RESET_WORD;
               end else if (tick) begin
                  sec_next = sec_reg + 16'h0001; // R18
               end
            end else begin
               sec_next = `RESET_WORD; // R18
            end
         end
         ST_ON: begin
            if (alarm_mode_reg != `MODE_NORMAL ||
               (!alarm_src_err && alarm_src <= off_thr_reg)) begin
               if (timer_done(sec_reg, off_dly_reg)) begin // R04 R07
                  state_next = ST_LOCK;
                  sec_next = `RESET_WORD;
               end else if (tick) begin
                  sec_next = sec_reg + 16'h0001;
               end
            end else begin
               sec_next = `RESET_WORD;
            end
         end
         ST_LOCK: begin
            if (timer_done(sec_reg, relock_reg)) begin // R08
               state_next = ST_OFF;
               sec_next = `RESET_WORD;
            end else if (tick) begin
               sec_next = sec_reg + 16'h0001;
            end
         end
         default: begin
            state_next = ST_OFF;
            sec_next = `RESET_WORD;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_reg <= ST_OFF;
         sec_reg <= `RESET_WORD;
         o_alarm <= 1'b0;
      end else begin
         state_reg <= state_next;
         sec_reg <= sec_next;
         o_alarm <= (state_next == ST_ON);
      end
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_current_setpoint <= 16'sh0000;
         o_current_fault <= 1'b0;
      end else if (out_src_err || out_mode_reg != `MODE_NORMAL) begin
         o_current_setpoint <= err_val_reg; // R15 R16
         o_current_fault <= 1'b1;
      end else begin
         o_current_setpoint <= scaled; // R13 R14 R17
         o_current_fault <= 1'b0;
      end
   end

   always @* begin
      rd_hit = 1'b1;
      case (i_reg_addr)
         `ADDR_ORDERED_POWER: rd_data = ordered_power_reg;
         `ADDR_ALARM_QTY: rd_data = alarm_qty_reg;
         `ADDR_ALARM_MODE: rd_data = alarm_mode_reg;
         `ADDR_ALARM_OFF_THR: rd_data = off_thr_reg;
         `ADDR_ALARM_ON_THR: rd_data = on_thr_reg;
         `ADDR_ALARM_ON_DLY: rd_data = on_dly_reg;
         `ADDR_ALARM_OFF_DLY: rd_data = off_dly_reg;
         `ADDR_ALARM_RELOCK: rd_data = relock_reg;
         `ADDR_OUT_QTY: rd_data = out_qty_reg;
         `ADDR_OUT_IN_LOW: rd_data = in_low_reg;
         `ADDR_OUT_IN_HIGH: rd_data = in_high_reg;
         `ADDR_OUT_CUR_LOW: rd_data = cur_low_reg;
         `ADDR_OUT_CUR_HIGH: rd_data = cur_high_reg;
         `ADDR_OUT_MODE: rd_data = out_mode_reg;
         `ADDR_OUT_ERR_VAL: rd_data = err_val_reg;
         default: begin
            rd_data = `RESET_WORD;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         ordered_power_reg <= `RESET_WORD;
         alarm_qty_reg <= `RESET_WORD;
         alarm_mode_reg <= `RESET_WORD;
         off_thr_reg <= `RESET_WORD;
         on_thr_reg <= `RESET_WORD;
         on_dly_reg <= `RESET_WORD;
         off_dly_reg <= `RESET_WORD;
         relock_reg <= `RESET_WORD;
         out_qty_reg <= `RESET_WORD;
         in_low_reg <= `RESET_WORD;
         in_high_reg <= `RESET_WORD;
         cur_low_reg <= `RESET_WORD;
         cur_high_reg <= `RESET_WORD;
         out_mode_reg <= `RESET_WORD;
         err_val_reg <= `ERR_VALUE_RESET;
         o_reg_rdata <= `RESET_WORD;
         o_reg_ack <= 1'b0;
         o_reg_err <= 1'b0;
      end else begin
         o_reg_ack <= (i_reg_wr || i_reg_rd) && rd_hit;
         o_reg_err <= (i_reg_wr || i_reg_rd) && !rd_hit;
         if (i_reg_rd)
            o_reg_rdata <= rd_data;
         if (i_reg_wr) begin
            case (i_reg_addr)
               `ADDR_ORDERED_POWER: ordered_power_reg <= i_reg_wdata;
               `ADDR_ALARM_QTY: alarm_qty_reg <= i_reg_wdata;
               `ADDR_ALARM_MODE: alarm_mode_reg <= i_reg_wdata;
               `ADDR_ALARM_OFF_THR: off_thr_reg <= i_reg_wdata;
               `ADDR_ALARM_ON_THR: on_thr_reg <= i_reg_wdata;
               `ADDR_ALARM_ON_DLY: on_dly_reg <= i_reg_wdata;
               `ADDR_ALARM_OFF_DLY: off_dly_reg <= i_reg_wdata;
               `ADDR_ALARM_RELOCK: relock_reg <= i_reg_wdata;
               `ADDR_OUT_QTY: out_qty_reg <= i_reg_wdata;
               `ADDR_OUT_IN_LOW: in_low_reg <= i_reg_wdata;
               `ADDR_OUT_IN_HIGH: in_high_reg <= i_reg_wdata;
               `ADDR_OUT_CUR_LOW: cur_low_reg <= i_reg_wdata;
               `ADDR_OUT_CUR_HIGH: cur_high_reg <= i_reg_wdata;
               `ADDR_OUT_MODE: out_mode_reg <= i_reg_wdata;
               `ADDR_OUT_ERR_VAL: err_val_reg <= i_reg_wdata;
               default: ordered_power_reg <= ordered_power_reg;
            endcase
         end
      end
   end
endmodule // alarm_analog_config
`default_nettype wire

// ### dv/alarm_analog_config_properties.sv
// Port checker for the alarm and output-1 block.
// Assumes binding to alarm_analog_config; shadows a few registers from bus writes.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_out_defs.vh"
module alarm_analog_config_properties (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_phase_one_voltage_err,
   input wire logic i_mean_current_err,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_ack,
   input wire logic o_reg_err,
   input wire logic o_alarm,
   input wire logic signed [15:0] o_current_setpoint,
   input wire logic o_current_fault
);
   logic [15:0] err_reg, oqty_reg, omode_reg, aqty_reg, amode_reg;
   wire logic acc = i_reg_wr | i_reg_rd;
   wire logic hit = (i_reg_addr == `ADDR_ORDERED_POWER)
      || (i_reg_addr >= `ADDR_ALARM_QTY && i_reg_addr <= `ADDR_ALARM_RELOCK)
      || (i_reg_addr >= `ADDR_OUT_QTY && i_reg_addr <= `ADDR_OUT_ERR_VAL);
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         err_reg <= `ERR_VALUE_RESET;
         oqty_reg <= `RESET_WORD;
         omode_reg <= `RESET_WORD;
         aqty_reg <= `RESET_WORD;
         amode_reg <= `RESET_WORD;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `ADDR_OUT_ERR_VAL: err_reg <= i_reg_wdata;
            `ADDR_OUT_QTY: oqty_reg <= i_reg_wdata;
            `ADDR_OUT_MODE: omode_reg <= i_reg_wdata;
            `ADDR_ALARM_QTY: aqty_reg <= i_reg_wdata;
            `ADDR_ALARM_MODE: amode_reg <= i_reg_wdata;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_ack; acc && hit |=> o_reg_ack && !o_reg_err; endproperty
   property p_unmapped;
      acc && !hit |=> o_reg_err && !o_reg_ack && (!$past(i_reg_rd) || o_reg_rdata == 16'h0000);
   endproperty
   property p_idle; !acc |=> !o_reg_ack && !o_reg_err; endproperty
   property p_rd_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
   property p_fb_val; o_current_fault |-> o_current_setpoint == $past(err_reg); endproperty
   property p_fb_on;
      oqty_reg == `QTY_MEAN_CURRENT && i_mean_current_err |=> o_current_fault;
   endproperty
   property p_fb_off;
      oqty_reg == `QTY_MEAN_CURRENT && !i_mean_current_err && omode_reg == `MODE_NORMAL
         |=> !o_current_fault;
   endproperty
   property p_alarm_hold;
      aqty_reg == `QTY_PHASE_ONE_VOLTAGE && i_phase_one_voltage_err && amode_reg == `MODE_NORMAL
         |=> $stable(o_alarm);
   endproperty
   a_ack: assert property (p_ack) else $error("no ack on mapped access");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_idle: assert property (p_idle) else $error("ack or err without access");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
   a_fb_val: assert property (p_fb_val) else $error("fault current not error value");
   a_fb_on: assert property (p_fb_on) else $error("source error not flagged");
   a_fb_off: assert property (p_fb_off) else $error("fault in normal mode");
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved on error");
   c_alarm: cover property ($rose(o_alarm));
   c_fault: cover property ($rose(o_current_fault));
   c_err: cover property (o_reg_err);
endmodule // alarm_analog_config_properties
bind alarm_analog_config alarm_analog_config_properties u_props (.i_sys_clk, .i_rst,
   .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_phase_one_voltage_err,
   .i_mean_current_err, .o_reg_rdata, .o_reg_ack, .o_reg_err, .o_alarm,
   .o_current_setpoint, .o_current_fault);
`default_nettype wire

// ### dv/relay_current_load.sv
// Relay contact and current output driver model.
// Assumes drive signals from the block, same clock.
`timescale 1ns/1ps
`default_nettype none
module relay_current_load (
   input wire logic i_sys_clk,
   input wire logic i_alarm,
   input wire logic signed [15:0] i_setpoint,
   output logic o_contact_closed,
   output logic signed [15:0] o_load_current
);
   // Contact settles a cycle late, like a real coil
   always_ff @(posedge i_sys_clk) begin
      o_contact_closed <= i_alarm;
   end
   // Driver saturates at 24 mA either way, hundredths of mA
   always_comb begin
      o_load_current = i_setpoint;
      if (i_setpoint > 16'sd2400)
         o_load_current = 16'sd2400;
      if (i_setpoint < -16'sd2400)
         o_load_current = -16'sd2400;
   end
endmodule // relay_current_load
`default_nettype wire

// ### dv/alarm_analog_config_bench.sv
// Self-checking bench for the alarm and output-1 block.
// Assumes CLK_HZ of 10, so one second is ten cycles.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_out_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module alarm_analog_config_bench;
   logic i_sys_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
   logic [15:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
   logic signed [15:0] v = 0, c = 0, p = 0, o_current_setpoint, load;
   logic v_err = 0, c_err = 0, p_err = 0, o_reg_ack, o_reg_err, o_alarm, o_current_fault, contact;
   int n_fail = 0, compares = 0, cycles = 0, n;
   alarm_analog_config #(.CLK_HZ(10)) u_dut (.i_sys_clk, .i_rst, .i_reg_wr, .i_reg_rd,
      .i_reg_addr, .i_reg_wdata, .i_phase_one_voltage(v), .i_phase_one_voltage_err(v_err),
      .i_mean_current(c), .i_mean_current_err(c_err), .i_avg_active_power(p),
      .i_avg_active_power_err(p_err), .o_reg_rdata, .o_reg_ack, .o_reg_err, .o_alarm,
      .o_current_setpoint, .o_current_fault);
   relay_current_load u_load (.i_sys_clk, .i_alarm(o_alarm), .i_setpoint(o_current_setpoint),
      .o_contact_closed(contact), .o_load_current(load));
   initial begin
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [15:0] a, d, input logic m,
         output logic [15:0] q);
      @(negedge i_sys_clk);
      i_reg_wr = w;
      i_reg_rd = !w;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_sys_clk);
      i_reg_wr = 0;
      i_reg_rd = 0;
      q = o_reg_rdata;
      `CHK(o_reg_ack, m)
      `CHK(o_reg_err, !m)
   endtask
   task automatic wr(input logic [15:0] a, d);
      logic [15:0] q;
      bus(1'b1, a, d, 1'b1, q);
   endtask
   task automatic wait_alarm(input logic lvl);
      n = 0;
      while (o_alarm !== lvl && n < 80) begin
         @(negedge i_sys_clk);
         n++;
      end
   endtask
   task automatic cfg_alarm(input logic [15:0] q, off, on, ond, offd, lock);
      wr(`ADDR_ALARM_RELOCK, lock);
      wr(`ADDR_ALARM_MODE, `MODE_NORMAL);
      wr(`ADDR_ALARM_QTY, q);
      wr(`ADDR_ALARM_OFF_THR, off);
      wr(`ADDR_ALARM_ON_THR, on);
      wr(`ADDR_ALARM_ON_DLY, ond);
      wr(`ADDR_ALARM_OFF_DLY, offd);
   endtask
   task automatic t_regs;
      logic [15:0] a, q;
      logic m;
      for (a = 16'h0FA9; a <= 16'h0FD7; a++) begin
         m = (a == `ADDR_ORDERED_POWER) || (a >= `ADDR_ALARM_QTY && a <= `ADDR_ALARM_RELOCK)
            || (a >= `ADDR_OUT_QTY && a <= `ADDR_OUT_ERR_VAL);
         bus(1'b0, a, 16'h0000, m, q);
         `CHK(q, (a == `ADDR_OUT_ERR_VAL) ? `ERR_VALUE_RESET : `RESET_WORD)
         bus(1'b1, a, ~a, m, q);
         bus(1'b0, a, 16'h0000, m, q);
         `CHK(q, m ? ~a : 16'h0000)
      end
   endtask
   task automatic t_hyst;
      cfg_alarm(`QTY_PHASE_ONE_VOLTAGE, 16'd913, 16'd1087, 0, 0, 0);
      v = 16'sd1086;
      repeat (4) @(negedge i_sys_clk);
      `CHK(o_alarm, 1'b0)
      v = 16'sd1087;
      wait_alarm(1'b1);
      `CHK(n, 1)
      v_err = 1;
      v = 16'sd0;
      repeat (3) @(negedge i_sys_clk);
      `CHK(o_alarm, 1'b1)
      v_err = 0;
      v = 16'sd914;
      repeat (3) @(negedge i_sys_clk);
      `CHK(contact, 1'b1)
      v = 16'sd913;
      wait_alarm(1'b0);
      `CHK(n, 1)
   endtask
   task automatic t_delay;
      cfg_alarm(`QTY_PHASE_ONE_VOLTAGE, 16'd913, 16'd1087, 2, 1, 2);
      v = 16'sd1100;
      wait_alarm(1'b1);
      `CHK(n > 20 && n <= 32, 1'b1)
      v = 16'sd900;
      wait_alarm(1'b0);
      `CHK(n > 10 && n <= 22, 1'b1)
      v = 16'sd1100;
      wait_alarm(1'b1);
      `CHK(n > 40 && n <= 64, 1'b1)
   endtask
   task automatic t_used;
      wr(`ADDR_ORDERED_POWER, 16'd579);
      cfg_alarm(`QTY_USED_ORDERED_POWER, 16'd890, 16'd900, 0, 0, 0);
      p = 16'sd521;
      repeat (4) @(negedge i_sys_clk);
      `CHK(o_alarm, 1'b0)
      p = 16'sd522;
      wait_alarm(1'b1);
      `CHK(n <= 2, 1'b1)
      wr(`ADDR_ORDERED_POWER, 16'd0);
      p = 16'sd0;
      repeat (4) @(negedge i_sys_clk);
      `CHK(o_alarm, 1'b1)
      wr(`ADDR_ALARM_MODE, 16'h0001);
      wait_alarm(1'b0);
      `CHK(n, 1)
   endtask
   task automatic t_point(input logic signed [15:0] il, ih, cl, ch, src, e);
      wr(`ADDR_OUT_QTY, `QTY_MEAN_CURRENT);
      wr(`ADDR_OUT_MODE, `MODE_NORMAL);
      wr(`ADDR_OUT_IN_LOW, il);
      wr(`ADDR_OUT_IN_HIGH, ih);
      wr(`ADDR_OUT_CUR_LOW, cl);
      wr(`ADDR_OUT_CUR_HIGH, ch);
      c = src;
      repeat (3) @(negedge i_sys_clk);
      `CHK(o_current_setpoint, e)
      `CHK(o_current_fault, 1'b0)
      `CHK(load, e)
   endtask
   task automatic t_fault;
      wr(`ADDR_OUT_ERR_VAL, `ERR_VALUE_RESET);
      c_err = 1;
      repeat (2) @(negedge i_sys_clk);
      `CHK(o_current_setpoint, 16'sh0960)
      wr(`ADDR_OUT_ERR_VAL, 16'h0190);
      @(negedge i_sys_clk);
      `CHK(o_current_setpoint, 16'sh0190)
      `CHK(o_current_fault, 1'b1)
      wr(`ADDR_OUT_MODE, 16'h0001);
      c_err = 0;
      repeat (3) @(negedge i_sys_clk);
      `CHK(o_current_setpoint, 16'sh0190)
      `CHK(o_current_fault, 1'b1)
   endtask
   initial begin
      repeat (2) @(negedge i_sys_clk);
      i_rst = 0;
      t_regs();
      t_hyst();
      t_delay();
      t_used();
      t_point(0, 800, 400, 2000, 400, 1200);
      t_point(0, 800, 400, 2000, 800, 2000);
      t_point(-800, 800, -2000, 2000, -400, -1000);
      t_point(-800, 800, -2000, 2000, 0, 0);
      t_fault();
      report_and_stop();
   end
endmodule // alarm_analog_config_bench
`default_nettype wire
